// [logic/lpm_reset_pkg.sv]
// constants, types and register map of the operating-mode and reset manager
// assumes a 32-bit AXI4-Lite register bus, one word per register
package lpm_reset_pkg;

  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_SYSTEM_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h04;
  localparam logic [7:0] OFS_RC_TRIM_ONE = 8'h08;
  localparam logic [7:0] OFS_RC_TRIM_TWO = 8'h0C;
  localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h10;
  localparam logic [7:0] OFS_MODE_STATUS = 8'h14;

  // system_control_reg fields
  localparam int unsigned BIT_SLEEP_PERMIT = 7;
  localparam int unsigned BIT_PCONF_RST_EN = 6;
  localparam int unsigned BIT_BUS_ERR_EN = 5;
  localparam int unsigned BIT_WDOG_EN = 4;

  // reset_cause_reg fields
  localparam int unsigned BIT_SLEEP_REQUEST = 7;
  localparam int unsigned BIT_SLEEP_HISTORY = 6;
  localparam int unsigned BIT_CAUSE_BUS_ERR = 5;
  localparam int unsigned BIT_CAUSE_WDOG = 4;
  localparam int unsigned BIT_CAUSE_PORT = 3;

  // rc trim registers: top bit is held by the cold reset only
  localparam logic [7:0] TRIM_COLD_MASK = 8'h80;
  localparam logic [7:0] TRIM_ONE_RESET = 8'h00;
  localparam logic [7:0] TRIM_TWO_RESET = 8'h00;

  // clock_config fields and reset values
  localparam int unsigned BIT_RC_EN = 0;
  localparam int unsigned BIT_XTAL_EN = 1;
  localparam int unsigned LSB_CPU_DIV = 4;
  localparam int unsigned CPU_DIV_W = 3;
  localparam logic RC_EN_RESET = 1'b1;
  localparam logic XTAL_EN_RESET = 1'b0;
  localparam logic [2:0] CPU_DIV_RESET = 3'h0;

  localparam logic [15:0] BOOT_ADDR = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // cycles the global reset is held after a source fires
  localparam int unsigned GLOBAL_HOLD_CYCLES = 16;

  typedef enum logic [1:0] {
    MODE_RESET = 2'b00,
    MODE_ACTIVE = 2'b01,
    MODE_STANDBY = 2'b10,
    MODE_SLEEP = 2'b11
  } op_mode_t;

  // distributed resets, all active low
  typedef struct packed {
    logic cold_n;
    logic global_n;
    logic pconf_n;
    logic sleep_n;
  } nreset_bus_t;

  localparam nreset_bus_t NRESET_ALL_ASSERTED = 4'h0;

endpackage

// [logic/sticky_flag.sv]
// one sticky status flag: hardware sets, a read clears
// assumes set and clear are one-cycle pulses in the clock domain
`timescale 1ns/10ps
module sticky_flag
  import lpm_reset_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);

  logic flag_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flag_q <= 1'b0;
    else if (ce_i)
    begin
      // set wins so an event on the clearing read is kept
      if (set_i)
        flag_q <= 1'b1;
      else if (clr_i)
        flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;

endmodule // sticky_flag

// [logic/hold_counter.sv]
// reloadable down-counter holding a reset asserted for LOAD cycles
// starts loaded out of reset so the cold start gets the same hold
`timescale 1ns/10ps
module hold_counter
  import lpm_reset_pkg::*;
#(
  parameter int unsigned LOAD = GLOBAL_HOLD_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic load_i,
  output logic busy_o
);

  localparam int unsigned CNT_W = $clog2(LOAD + 1);
  localparam logic [CNT_W-1:0] LOAD_VAL = CNT_W'(LOAD);

  if (LOAD < 1)
  begin : g_chk
    $error("hold_counter: LOAD must be at least 1");
  end

  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_q <= LOAD_VAL;
    else if (ce_i)
    begin
      if (load_i)
        cnt_q <= LOAD_VAL;
      else if (cnt_q != '0)
        cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  assign busy_o = (cnt_q != '0);

endmodule // hold_counter

// [logic/lpm_reset_ctrl.sv]
// operating-mode and reset manager with its AXI4-Lite register slave
// assumes all inputs synchronous to REF_CLK_I; NRST_I merges power-on and reset pin
`timescale 1ns/10ps
// Overview of operation
// - power-on or reset pin returns every register bit to its reset value
// - cold start: RC on, crystal off, processor held in reset at address zero
// - port combination wake keeps every cold-reset bit unchanged except the port cause flag, which it sets
// - held bits: cause register except sleep request, trim top bits
// - non-cold reset clears global bits, port-config bits if enabled, resets processor
// - non-cold reset keeps clock setup except the processor divider
// - halt instruction enters Standby
// - Standby stops the processor, clocks keep running
// - Standby ends on any reset or enabled interrupt or event request
// - Sleep stops all clocks and peripherals
// - sleep request write with permit already set enters Sleep
// - Sleep ends only on power-on, reset pin or port combination
// - sleep history flag reads one after Sleep until cleared
// - manager gathers reset sources, distributes resets, controls Sleep entry
// - global reset follows cold reset or any enabled source
// - port-config reset follows global reset only when enabled; cold always
// - sleep reset asserted throughout Sleep
// - sleep request is bit 7, cleared by global reset, reads zero
module lpm_reset_ctrl
  import lpm_reset_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = GLOBAL_HOLD_CYCLES
)
(
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic PORT_COMBO_WAKE_I,
  input wire logic WDOG_EXPIRE_I,
  input wire logic BUS_ERROR_I,
  input wire logic CPU_HALT_I,
  input wire logic WAKE_REQ_I,
  input wire logic [AXI_ADDR_W-1:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [AXI_DATA_W-1:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  input wire logic [AXI_ADDR_W-1:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [AXI_DATA_W-1:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I,
  output nreset_bus_t NRESETS_O,
  output logic CPU_NRESET_O,
  output logic CPU_RUN_O,
  output logic [15:0] CPU_BOOT_ADDR_O,
  output logic CLK_RUN_O,
  output logic PERIPH_RUN_O,
  output logic RC_EN_O,
  output logic XTAL_EN_O,
  output logic [CPU_DIV_W-1:0] CPU_DIV_O,
  output op_mode_t MODE_O
);

  if (HOLD_CYCLES < 1)
  begin : g_chk
    $error("lpm_reset_ctrl: HOLD_CYCLES must be at least 1");
  end

  // configuration, cold reset domain; trim bits below the top one are global
  logic sleep_permit_q;
  logic port_config_reset_enable_q;
  logic bus_err_en_q;
  logic wdog_en_q;
  logic rc_en_q;
  logic xtal_en_q;
  logic [7:0] trim_one_q;
  logic [7:0] trim_two_q;
  // global reset domain
  logic [CPU_DIV_W-1:0] cpu_div_q;

  op_mode_t mode_q;
  op_mode_t mode_d;
  logic cold_phase_q;
  logic glob_busy;
  logic glob_start;
  logic glob_act;
  logic sleep_go;

  logic sleep_history_flag;
  logic cause_bus_err;
  logic cause_wdog;
  logic port_combo_wake_reset;

  // bus slave state
  logic aw_full_q;
  logic w_full_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic wr_hit;
  logic cause_read;
  logic [AXI_DATA_W-1:0] rd_word;
  logic rd_hit;

  assign aw_hs = AXI_AWVALID_I && AXI_AWREADY_O;
  assign w_hs = AXI_WVALID_I && AXI_WREADY_O;
  assign ar_hs = AXI_ARVALID_I && AXI_ARREADY_O;
  assign do_write = aw_full_q && w_full_q && !AXI_BVALID_O;
  assign cause_read = ar_hs && (AXI_ARADDR_I == OFS_RESET_CAUSE);

  // sleep stops every clock, so only the port combination is seen there
  assign glob_start = PORT_COMBO_WAKE_I ||
                      ((mode_q != MODE_SLEEP) && ((WDOG_EXPIRE_I && wdog_en_q) ||
                      (BUS_ERROR_I && bus_err_en_q)));
  assign glob_act = glob_start || glob_busy;

  // sleep entry needs the permit already stored before this write
  assign sleep_go = do_write && wlane_q && (awaddr_q == OFS_RESET_CAUSE) &&
                    wdata_q[BIT_SLEEP_REQUEST] && sleep_permit_q &&
                    (mode_q == MODE_ACTIVE) && !glob_act;

  hold_counter #(
    .LOAD(HOLD_CYCLES)
  ) u_global_hold (
    .clk_i(REF_CLK_I),
    .rst_n_i(NRST_I),
    .ce_i(CE_I),
    .load_i(glob_start),
    .busy_o(glob_busy)
  );

  // cause flags live in the cold domain and survive a port wake
  sticky_flag u_hist (
    .clk_i(REF_CLK_I),
    .rst_n_i(NRST_I),
    .ce_i(CE_I),
    .set_i(sleep_go),
    .clr_i(cause_read),
    .flag_o(sleep_history_flag)
  );

  sticky_flag u_cause_bus (
    .clk_i(REF_CLK_I),
    .rst_n_i(NRST_I),
    .ce_i(CE_I),
    .set_i(BUS_ERROR_I && bus_err_en_q && (mode_q != MODE_SLEEP)),
    .clr_i(cause_read),
    .flag_o(cause_bus_err)
  );

  sticky_flag u_cause_wdog (
    .clk_i(REF_CLK_I),
    .rst_n_i(NRST_I),
    .ce_i(CE_I),
    .set_i(WDOG_EXPIRE_I && wdog_en_q && (mode_q != MODE_SLEEP)),
    .clr_i(cause_read),
    .flag_o(cause_wdog)
  );

  sticky_flag u_cause_port (
    .clk_i(REF_CLK_I),
    .rst_n_i(NRST_I),
    .ce_i(CE_I),
    .set_i(PORT_COMBO_WAKE_I),
    .clr_i(cause_read),
    .flag_o(port_combo_wake_reset)
  );

  // mode sequencing
  always_comb
  begin
    mode_d = mode_q;
    if (glob_start)
      mode_d = MODE_RESET;
    else
    begin
      case (mode_q)
        MODE_RESET:
          if (!glob_busy)
            mode_d = MODE_ACTIVE;
        MODE_ACTIVE:
          if (sleep_go)
            mode_d = MODE_SLEEP;
          else if (CPU_HALT_I)
            mode_d = MODE_STANDBY;
        MODE_STANDBY:
          if (WAKE_REQ_I)
            mode_d = MODE_ACTIVE;
        MODE_SLEEP:
          mode_d = MODE_SLEEP;
        default:
          mode_d = MODE_RESET;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      mode_q <= MODE_RESET;
      cold_phase_q <= 1'b1;
    end
    else if (CE_I)
    begin
      mode_q <= mode_d;
      if (!glob_busy)
        cold_phase_q <= 1'b0;
    end
  end

  // cold-domain configuration; a port wake never touches these
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      sleep_permit_q <= 1'b0;
      port_config_reset_enable_q <= 1'b0;
      bus_err_en_q <= 1'b0;
      wdog_en_q <= 1'b0;
      rc_en_q <= RC_EN_RESET;
      xtal_en_q <= XTAL_EN_RESET;
    end
    else if (CE_I && do_write && wlane_q)
    begin
      if (awaddr_q == OFS_SYSTEM_CONTROL)
      begin
        sleep_permit_q <= wdata_q[BIT_SLEEP_PERMIT];
        port_config_reset_enable_q <= wdata_q[BIT_PCONF_RST_EN];
        bus_err_en_q <= wdata_q[BIT_BUS_ERR_EN];
        // watchdog enable cannot be withdrawn by software
        wdog_en_q <= wdog_en_q || wdata_q[BIT_WDOG_EN];
      end
      if (awaddr_q == OFS_CLOCK_CONFIG)
      begin
        rc_en_q <= wdata_q[BIT_RC_EN];
        xtal_en_q <= wdata_q[BIT_XTAL_EN];
      end
    end
  end

  // trim registers: cold bits kept, global bits cleared by a non-cold reset
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      trim_one_q <= TRIM_ONE_RESET;
      trim_two_q <= TRIM_TWO_RESET;
    end
    else if (CE_I)
    begin
      if (glob_act)
      begin
        trim_one_q <= (trim_one_q & TRIM_COLD_MASK) | (TRIM_ONE_RESET & ~TRIM_COLD_MASK);
        trim_two_q <= (trim_two_q & TRIM_COLD_MASK) | (TRIM_TWO_RESET & ~TRIM_COLD_MASK);
      end
      else if (do_write && wlane_q && (awaddr_q == OFS_RC_TRIM_ONE))
        trim_one_q <= wdata_q;
      else if (do_write && wlane_q && (awaddr_q == OFS_RC_TRIM_TWO))
        trim_two_q <= wdata_q;
    end
  end

  // processor divider is the one clock setting a non-cold reset restores
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      cpu_div_q <= CPU_DIV_RESET;
    else if (CE_I)
    begin
      if (glob_act)
        cpu_div_q <= CPU_DIV_RESET;
      else if (do_write && wlane_q && (awaddr_q == OFS_CLOCK_CONFIG))
        cpu_div_q <= wdata_q[LSB_CPU_DIV +: CPU_DIV_W];
    end
  end

  // distributed resets and run controls, registered
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      NRESETS_O <= NRESET_ALL_ASSERTED;
      CPU_NRESET_O <= 1'b0;
      CPU_RUN_O <= 1'b0;
      CPU_BOOT_ADDR_O <= BOOT_ADDR;
      CLK_RUN_O <= 1'b1;
      PERIPH_RUN_O <= 1'b1;
      RC_EN_O <= RC_EN_RESET;
      XTAL_EN_O <= XTAL_EN_RESET;
      CPU_DIV_O <= CPU_DIV_RESET;
      MODE_O <= MODE_RESET;
    end
    else if (CE_I)
    begin
      NRESETS_O.cold_n <= 1'b1;
      NRESETS_O.global_n <= !glob_act;
      NRESETS_O.pconf_n <= !(glob_act && (port_config_reset_enable_q || cold_phase_q));
      NRESETS_O.sleep_n <= (mode_d != MODE_SLEEP);
      CPU_NRESET_O <= (mode_d != MODE_RESET);
      CPU_RUN_O <= (mode_d == MODE_ACTIVE);
      CPU_BOOT_ADDR_O <= BOOT_ADDR;
      // standby keeps clocks for timekeeping; sleep drops everything
      CLK_RUN_O <= (mode_d != MODE_SLEEP);
      PERIPH_RUN_O <= (mode_d != MODE_SLEEP);
      RC_EN_O <= rc_en_q && (mode_d != MODE_SLEEP);
      XTAL_EN_O <= xtal_en_q && (mode_d != MODE_SLEEP);
      CPU_DIV_O <= glob_act ? CPU_DIV_RESET : cpu_div_q;
      MODE_O <= mode_d;
    end
  end

  // write channel: address and data taken in either order
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      AXI_AWREADY_O <= 1'b1;
      AXI_WREADY_O <= 1'b1;
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (aw_hs)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= AXI_AWADDR_I;
        AXI_AWREADY_O <= 1'b0;
      end
      if (w_hs)
      begin
        w_full_q <= 1'b1;
        wdata_q <= AXI_WDATA_I[7:0];
        wlane_q <= AXI_WSTRB_I[0];
        AXI_WREADY_O <= 1'b0;
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        AXI_BVALID_O <= 1'b1;
        AXI_BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (AXI_BVALID_O && AXI_BREADY_I)
      begin
        AXI_BVALID_O <= 1'b0;
        AXI_AWREADY_O <= 1'b1;
        AXI_WREADY_O <= 1'b1;
      end
    end
  end

  // status register is read-only, writing it answers an error
  assign wr_hit = (awaddr_q == OFS_SYSTEM_CONTROL) || (awaddr_q == OFS_RESET_CAUSE) ||
                  (awaddr_q == OFS_RC_TRIM_ONE) || (awaddr_q == OFS_RC_TRIM_TWO) ||
                  (awaddr_q == OFS_CLOCK_CONFIG);

  // read mux
  always_comb
  begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (AXI_ARADDR_I)
      OFS_SYSTEM_CONTROL:
      begin
        rd_word[BIT_SLEEP_PERMIT] = sleep_permit_q;
        rd_word[BIT_PCONF_RST_EN] = port_config_reset_enable_q;
        rd_word[BIT_BUS_ERR_EN] = bus_err_en_q;
        rd_word[BIT_WDOG_EN] = wdog_en_q;
      end
      OFS_RESET_CAUSE:
      begin
        rd_word[BIT_SLEEP_REQUEST] = 1'b0;
        rd_word[BIT_SLEEP_HISTORY] = sleep_history_flag;
        rd_word[BIT_CAUSE_BUS_ERR] = cause_bus_err;
        rd_word[BIT_CAUSE_WDOG] = cause_wdog;
        rd_word[BIT_CAUSE_PORT] = port_combo_wake_reset;
      end
      OFS_RC_TRIM_ONE:
        rd_word[7:0] = trim_one_q;
      OFS_RC_TRIM_TWO:
        rd_word[7:0] = trim_two_q;
      OFS_CLOCK_CONFIG:
      begin
        rd_word[BIT_RC_EN] = rc_en_q;
        rd_word[BIT_XTAL_EN] = xtal_en_q;
        rd_word[LSB_CPU_DIV +: CPU_DIV_W] = cpu_div_q;
      end
      OFS_MODE_STATUS:
      begin
        rd_word[1:0] = mode_q;
        rd_word[2] = glob_act;
        rd_word[3] = cold_phase_q;
      end
      default:
        rd_hit = 1'b0;
    endcase
  end

  // read channel: one read in flight, data one cycle after the address
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      AXI_ARREADY_O <= 1'b1;
      AXI_RVALID_O <= 1'b0;
      AXI_RDATA_O <= '0;
      AXI_RRESP_O <= RESP_OKAY;
    end
    else if (CE_I)
    begin
      if (ar_hs)
      begin
        AXI_ARREADY_O <= 1'b0;
        AXI_RVALID_O <= 1'b1;
        AXI_RDATA_O <= rd_word;
        AXI_RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (AXI_RVALID_O && AXI_RREADY_I)
      begin
        AXI_RVALID_O <= 1'b0;
        AXI_ARREADY_O <= 1'b1;
      end
    end
  end

endmodule // lpm_reset_ctrl

// [verification/lpm_reset_monitor.sv]
// checker of the mode and reset manager outputs
// assumes one clock domain; bound to the manager below
`timescale 1ns/10ps
module lpm_reset_monitor
  import lpm_reset_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = GLOBAL_HOLD_CYCLES
)
(
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic PORT_COMBO_WAKE_I,
  input wire logic WDOG_EXPIRE_I,
  input wire logic BUS_ERROR_I,
  input wire logic CPU_HALT_I,
  input wire logic WAKE_REQ_I,
  input wire logic [AXI_DATA_W-1:0] AXI_RDATA_O,
  input wire logic AXI_RVALID_O,
  input wire nreset_bus_t NRESETS_O,
  input wire logic CPU_NRESET_O,
  input wire logic CPU_RUN_O,
  input wire logic [15:0] CPU_BOOT_ADDR_O,
  input wire logic CLK_RUN_O,
  input wire logic PERIPH_RUN_O,
  input wire logic RC_EN_O,
  input wire logic XTAL_EN_O,
  input wire logic [CPU_DIV_W-1:0] CPU_DIV_O,
  input wire op_mode_t MODE_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (!NRST_I);
  logic quiet;
  logic [7:0] low_q;
  assign quiet = CE_I && !PORT_COMBO_WAKE_I && !WDOG_EXPIRE_I && !BUS_ERROR_I;
  // restarts on any source pulse, so disabled pulses only make it lenient
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      low_q <= 8'h00;
    else if (NRESETS_O.global_n || !quiet)
      low_q <= 8'h00;
    else if (low_q != 8'hFF)
      low_q <= low_q + 8'h01;
  end
  sequence s_halt;
    MODE_O == MODE_ACTIVE && CPU_HALT_I && quiet;
  endsequence
  sequence s_standby;
    MODE_O == MODE_STANDBY && !CPU_RUN_O;
  endsequence
  AST_BOOT: assert property (CPU_BOOT_ADDR_O == BOOT_ADDR)
    else $error("boot address moved");
  AST_HELD: assert property (MODE_O == MODE_RESET |-> !CPU_NRESET_O && !CPU_RUN_O)
    else $error("core free in reset");
  AST_HALT: assert property (s_halt |=> s_standby)
    else $error("halt ignored");
  AST_STANDBY: assert property (MODE_O == MODE_STANDBY |-> CLK_RUN_O && PERIPH_RUN_O && !CPU_RUN_O)
    else $error("standby clocks wrong");
  AST_WAKE: assert property (s_standby ##0 WAKE_REQ_I && CE_I |=> MODE_O != MODE_STANDBY)
    else $error("wake ignored");
  AST_SLEEP: assert property (MODE_O == MODE_SLEEP |-> !CLK_RUN_O && !PERIPH_RUN_O && !RC_EN_O && !XTAL_EN_O)
    else $error("sleep left clocks on");
  AST_SLEEP_RST: assert property (MODE_O == MODE_SLEEP |-> !NRESETS_O.sleep_n)
    else $error("sleep reset missing");
  AST_STAY: assert property (MODE_O == MODE_SLEEP && !PORT_COMBO_WAKE_I |=> MODE_O == MODE_SLEEP)
    else $error("sleep left early");
  AST_PORT: assert property (PORT_COMBO_WAKE_I && CE_I |=> !NRESETS_O.global_n && NRESETS_O.cold_n
    && !CPU_NRESET_O && CPU_DIV_O == CPU_DIV_RESET)
    else $error("port reset wrong");
  AST_PCONF: assert property (NRESETS_O.global_n |-> NRESETS_O.pconf_n)
    else $error("pconf without global");
  AST_HOLD: assert property (low_q <= HOLD_CYCLES + 4)
    else $error("global reset stuck");
  AST_RDATA: assert property (AXI_RVALID_O |-> AXI_RDATA_O[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule // lpm_reset_monitor

bind lpm_reset_ctrl lpm_reset_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) lpm_reset_monitor_i (
  .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .CE_I(CE_I), .PORT_COMBO_WAKE_I(PORT_COMBO_WAKE_I),
  .WDOG_EXPIRE_I(WDOG_EXPIRE_I), .BUS_ERROR_I(BUS_ERROR_I), .CPU_HALT_I(CPU_HALT_I), .WAKE_REQ_I(WAKE_REQ_I),
  .AXI_RDATA_O(AXI_RDATA_O), .AXI_RVALID_O(AXI_RVALID_O), .NRESETS_O(NRESETS_O), .CPU_NRESET_O(CPU_NRESET_O),
  .CPU_RUN_O(CPU_RUN_O), .CPU_BOOT_ADDR_O(CPU_BOOT_ADDR_O), .CLK_RUN_O(CLK_RUN_O), .PERIPH_RUN_O(PERIPH_RUN_O),
  .RC_EN_O(RC_EN_O), .XTAL_EN_O(XTAL_EN_O), .CPU_DIV_O(CPU_DIV_O), .MODE_O(MODE_O));

// [verification/lpm_core_model.sv]
// processor core model: halts on command, passes wake requests
// assumes one-cycle commands from the bench
`timescale 1ns/10ps
module lpm_core_model
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cpu_run_i,
  input wire logic halt_cmd_i,
  input wire logic wake_cmd_i,
  output logic halt_o,
  output logic wake_o
);
  // a stopped core cannot execute a halt
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      halt_o <= 1'b0;
      wake_o <= 1'b0;
    end
    else
    begin
      halt_o <= halt_cmd_i & cpu_run_i;
      wake_o <= wake_cmd_i;
    end
  end
endmodule // lpm_core_model

// [verification/lpm_reset_ctrl_tb.sv]
// bench of the mode and reset manager: bus tasks and sequenced checks
// assumes the monitor is bound to the manager
`timescale 1ns/10ps
module lpm_reset_ctrl_tb
  import lpm_reset_pkg::*;
;
  // short hold keeps every reset wait brief
  localparam int unsigned HOLD = 2;
  logic clk = 1'b0, nrst = 1'b0, combo = 1'b0, wdog = 1'b0, berr = 1'b0, hcmd = 1'b0, wcmd = 1'b0, ce = 1'b1;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rd;
  logic halt, wake, awr, wr_r, bv, arr, rv, cnr, run, ckr, pr, rc, xt;
  logic [1:0] br, rr, resp;
  logic [15:0] boot;
  logic [2:0] div;
  nreset_bus_t nres;
  op_mode_t mode;
  int errors = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  task automatic fail(input string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
      fail(m);
  endtask
  // waits as long as the slave needs; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    resp = 2'h3;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    while (resp === 2'h3)
    begin
      @(posedge clk);
      if (awr === 1'b1)
        awv <= 1'b0;
      if (wr_r === 1'b1)
        wv <= 1'b0;
      if (bv === 1'b1)
        resp = br;
    end
    brdy <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    resp = 2'h3;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    while (resp === 2'h3)
    begin
      @(posedge clk);
      if (arr === 1'b1)
        arv <= 1'b0;
      if (rv === 1'b1)
      begin
        resp = rr;
        rd = rdat;
      end
    end
    rrdy <= 1'b0;
    cmp(rd, exp, "read data");
    cmp(resp, er, "read resp");
  endtask
  task automatic src(input int s);
    @(posedge clk);
    combo <= (s == 0);
    wdog <= (s == 1);
    berr <= (s == 2);
    @(posedge clk);
    {combo, wdog, berr} <= 3'b000;
    @(posedge clk);
    #1;
  endtask
  task automatic core(input logic h);
    @(posedge clk);
    hcmd <= h;
    wcmd <= !h;
    @(posedge clk);
    {hcmd, wcmd} <= 2'b00;
  endtask
  task automatic wmode(input op_mode_t m);
    int k;
    k = 0;
    while (mode !== m && k < 200)
    begin
      @(posedge clk);
      k++;
    end
    #1;
    cmp(mode, m, "mode");
  endtask
  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    cmp(nres, NRESET_ALL_ASSERTED, "cold resets");
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    cmp({cnr, mode}, {1'b0, MODE_RESET}, "core held");
    wmode(MODE_ACTIVE);
    cmp({rc, xt, boot, div}, {1'b1, 1'b0, BOOT_ADDR, CPU_DIV_RESET}, "cold outputs");
    for (int i = 0; i < 7; i++)
      rchk(8'(4 * i), (i == 4 || i == 5) ? 32'h1 : 32'h0, (i == 6) ? RESP_SLVERR : RESP_OKAY);
    $display("test cold start done");
    wr(OFS_RESET_CAUSE, 32'h80);
    repeat (2) @(posedge clk);
    #1;
    cmp(mode, MODE_ACTIVE, "sleep without permit");
    wr(OFS_MODE_STATUS, 32'hFF);
    cmp(resp, RESP_SLVERR, "read-only write");
    wr(OFS_CLOCK_CONFIG, 32'h53);
    wr(OFS_RC_TRIM_ONE, 32'hFF);
    wr(OFS_RC_TRIM_TWO, 32'h85);
    src(0);
    cmp({nres, cnr, div}, 8'hB0, "port reset");
    wmode(MODE_ACTIVE);
    cmp({rc, xt, div}, 5'b11000, "clock kept");
    rchk(OFS_CLOCK_CONFIG, 32'h03, RESP_OKAY);
    rchk(OFS_RC_TRIM_ONE, 32'h80, RESP_OKAY);
    rchk(OFS_RC_TRIM_TWO, 32'h80, RESP_OKAY);
    rchk(OFS_RESET_CAUSE, 32'h08, RESP_OKAY);
    rchk(OFS_RESET_CAUSE, 32'h00, RESP_OKAY);
    for (int s = 1; s < 3; s++)
    begin
      src(s);
      cmp(mode, MODE_ACTIVE, "disabled source");
      wr(OFS_SYSTEM_CONTROL, 32'h40 | (32'h10 << (s - 1)));
      src(s);
      cmp(nres, 4'b1001, "enabled source");
      wmode(MODE_ACTIVE);
      rchk(OFS_RESET_CAUSE, 32'h10 << (s - 1), RESP_OKAY);
    end
    $display("test global resets done");
    core(1'b1);
    wmode(MODE_STANDBY);
    cmp({run, ckr, pr}, 3'b011, "standby");
    core(1'b0);
    wmode(MODE_ACTIVE);
    core(1'b1);
    wmode(MODE_STANDBY);
    src(0);
    cmp(mode, MODE_RESET, "reset ends standby");
    wmode(MODE_ACTIVE);
    $display("test standby done");
    // a frozen block must not even see a port combination pulse
    @(posedge clk);
    ce <= 1'b0;
    src(0);
    cmp({mode, cnr}, {MODE_ACTIVE, 1'b1}, "clock enable low");
    @(posedge clk);
    ce <= 1'b1;
    $display("test clock enable done");
    wr(OFS_SYSTEM_CONTROL, 32'h80);
    wr(OFS_RESET_CAUSE, 32'h80);
    // idle slot after the request, the core may replay it on wake
    @(posedge clk);
    #1;
    cmp({mode, nres.sleep_n, ckr, pr, rc, xt}, {MODE_SLEEP, 5'b00000}, "asleep");
    core(1'b0);
    core(1'b1);
    repeat (4) @(posedge clk);
    #1;
    cmp(mode, MODE_SLEEP, "sleep held");
    src(0);
    wmode(MODE_ACTIVE);
    rchk(OFS_CLOCK_CONFIG, 32'h03, RESP_OKAY);
    rchk(OFS_RC_TRIM_TWO, 32'h80, RESP_OKAY);
    rchk(OFS_RESET_CAUSE, 32'h48, RESP_OKAY);
    rchk(OFS_RESET_CAUSE, 32'h00, RESP_OKAY);
    $display("test sleep done");
    // permit survived the port wake, so sleep again and leave by the pin
    wr(OFS_RESET_CAUSE, 32'h80);
    @(posedge clk);
    #1;
    cmp(mode, MODE_SLEEP, "asleep again");
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wmode(MODE_ACTIVE);
    rchk(OFS_SYSTEM_CONTROL, 32'h00, RESP_OKAY);
    rchk(OFS_CLOCK_CONFIG, 32'h01, RESP_OKAY);
    rchk(OFS_RESET_CAUSE, 32'h00, RESP_OKAY);
    $display("test pin reset done");
    results;
  end
  initial
  begin
    #100us;
    fail("watchdog expired");
    results;
  end
  lpm_core_model lpm_core_model_i (.clk_i(clk), .rst_n_i(nrst), .cpu_run_i(run), .halt_cmd_i(hcmd),
    .wake_cmd_i(wcmd), .halt_o(halt), .wake_o(wake));
  lpm_reset_ctrl #(.HOLD_CYCLES(HOLD)) lpm_reset_ctrl_i (.REF_CLK_I(clk), .NRST_I(nrst), .CE_I(ce),
    .PORT_COMBO_WAKE_I(combo), .WDOG_EXPIRE_I(wdog), .BUS_ERROR_I(berr), .CPU_HALT_I(halt), .WAKE_REQ_I(wake),
    .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv), .AXI_AWREADY_O(awr), .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hF),
    .AXI_WVALID_I(wv), .AXI_WREADY_O(wr_r), .AXI_BRESP_O(br), .AXI_BVALID_O(bv), .AXI_BREADY_I(brdy),
    .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_RDATA_O(rdat), .AXI_RRESP_O(rr),
    .AXI_RVALID_O(rv), .AXI_RREADY_I(rrdy), .NRESETS_O(nres), .CPU_NRESET_O(cnr), .CPU_RUN_O(run),
    .CPU_BOOT_ADDR_O(boot), .CLK_RUN_O(ckr), .PERIPH_RUN_O(pr), .RC_EN_O(rc), .XTAL_EN_O(xt),
    .CPU_DIV_O(div), .MODE_O(mode));
endmodule // lpm_reset_ctrl_tb
